//--- hdl/dclt_tuner.sv
/*
 Closed-loop tuner of the frequency-locked loop: measures output cycles
 per reference period, tracks coarse then fine, detects a stopped
 reference and raises a masked interrupt. Assumes CLK_I is the loop
 output clock and the reference arrives asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module dclt_tuner (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic REF_CLK_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	output logic IRQ_O,
	output logic [dclt_pkg::DCLT_COARSE_W-1:0] COARSE_O,
	output logic [dclt_pkg::DCLT_FINE_W-1:0] FINE_O
);
	import dclt_pkg::*;
	localparam logic [DCLT_CNT_W-1:0] STOP_LIM =
		DCLT_CNT_W'(DCLT_STOP_CYCLES);
	dclt_bus_t bus; // Bundled request
	logic ref_lvl; // Synchronised reference
	logic ref_rise; // Reference edge pulse
	logic [7:0] ctrl; // Control register
	logic [DCLT_MULT_W-1:0] mult; // Multiplication factor
	logic [DCLT_COARSE_W-1:0] coarse; // Coarse tuning value
	logic [DCLT_FINE_W-1:0] fine; // Fine tuning value
	logic [DCLT_CNT_W-1:0] cnt; // Output cycles in this period
	logic [DCLT_CNT_W-1:0] stop_cnt; // Cycles since last edge
	logic signed [DCLT_MULT_W:0] diff; // Ratio difference
	logic oob, lockc, lockf, rcs, ready; // Status
	logic [DCLT_ST_W-1:0] flags; // Sticky interrupt flags
	logic [DCLT_ST_W-1:0] mask; // Interrupt mask
	logic rcs_prev, oob_prev, lockc_prev, lockf_prev, rdy_prev;
	logic chill; // Skip next measurement
	logic [2:0] hits; // Consecutive in-tolerance measurements
	logic enable_prev; // Enable bit last cycle
	dclt_state_t state;
	dclt_state_t next_state;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	// Reference clock enters through two flops
	dclt_sync u_ref_sync (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.async_i(REF_CLK_I),
		.level_o(ref_lvl),
		.rise_o(ref_rise)
	);

	// Decode of writes; ready gates loop control writes
	wire wr_ctrl = bus.wr && bus.addr == DCLT_ADDR_CTRL;
	wire wr_mult = bus.wr && bus.addr == DCLT_ADDR_MULT && ready;
	wire wr_val = bus.wr && bus.addr == DCLT_ADDR_VAL && ready;
	wire wr_mask = bus.wr && bus.addr == DCLT_ADDR_IRQ_MASK;
	wire rd_flags = bus.rd && bus.addr == DCLT_ADDR_IRQ_FLAGS;
	wire ctrl_ok = wr_ctrl && ready;
	wire en = ctrl[DCLT_CTRL_ENABLE];
	wire closed = ctrl[DCLT_CTRL_CLOSED];
	wire stable = ctrl[DCLT_CTRL_STABLE];
	// Chill cycles skip every other measurement unless disabled
	wire chill_on = ~ctrl[DCLT_CTRL_CCDIS];
	// Quick lock widens the fine tolerance unless disabled
	wire [DCLT_CNT_W-1:0] tol =
		ctrl[DCLT_CTRL_QLDIS] ? DCLT_TOL_STRICT : DCLT_TOL_QUICK;
	wire tracking = state == DCLT_COARSE || state == DCLT_FINE;
	// A measurement is a completed reference period, not chilled
	wire measure = tracking && ref_rise && !rcs && !chill;
	wire [DCLT_CNT_W:0] err_w = {1'b0, cnt} - {3'b000, mult};
	wire signed [DCLT_CNT_W:0] err = err_w;
	wire fast = err > 0;
	wire [DCLT_CNT_W:0] mag_w = fast ? err_w : -err_w;
	wire [DCLT_CNT_W-1:0] mag = mag_w[DCLT_CNT_W-1:0];
	wire fine_hi = fine == DCLT_FINE_MAX;
	wire fine_lo = fine == DCLT_FINE_MIN;
	// Overflow attempt when pushing past a bound
	wire fine_clip = measure && state == DCLT_FINE && mag != '0 &&
		((fast && fine_lo) || (!fast && fine_hi));
	// Turning off with lose-lock set drops the locks
	wire turn_off = enable_prev && !en;
	wire lose = turn_off && ctrl[DCLT_CTRL_LLAW];
	wire [DCLT_ST_W-1:0] rise_ev = {rcs & ~rcs_prev, lockc & ~lockc_prev,
		lockf & ~lockf_prev, oob & ~oob_prev, ready & ~rdy_prev};

	// Next state of the tuner
	always_comb begin
		next_state = state;
		case (state)
			DCLT_OFF: begin
				if (en)
					next_state = !closed ? DCLT_OPEN :
						(lockc ? DCLT_FINE : DCLT_COARSE);
			end
			DCLT_OPEN: begin
				if (!en)
					next_state = DCLT_OFF;
				else if (closed)
					next_state = lockc ? DCLT_FINE : DCLT_COARSE;
			end
			DCLT_COARSE: begin
				if (!en)
					next_state = DCLT_OFF;
				else if (!closed)
					next_state = DCLT_OPEN;
				else if (measure && mag <= DCLT_TOL_COARSE)
					next_state = DCLT_FINE;
			end
			DCLT_FINE: begin
				if (!en)
					next_state = DCLT_OFF;
				else if (!closed)
					next_state = DCLT_OPEN;
			end
			default: next_state = DCLT_OFF;
		endcase
	end

	// State, control and loop registers
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state <= DCLT_OFF;
			ctrl <= DCLT_CTRL_RST;
			mult <= DCLT_MULT_RST;
			mask <= '0;
			ready <= 1'b0;
			enable_prev <= 1'b0;
		end else begin
			state <= lose ? DCLT_OFF : next_state;
			ready <= 1'b1;
			enable_prev <= en;
			if (ctrl_ok)
				ctrl <= bus.wdata[7:0];
			if (wr_mult)
				mult <= bus.wdata;
			if (wr_mask)
				mask <= bus.wdata[DCLT_ST_W-1:0];
		end
	end

	// Reference period counter and stop detection
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cnt <= '0;
			stop_cnt <= '0;
			rcs <= 1'b0;
		end else begin
			if (ref_rise) begin
				// The edge cycle is the first of the new period
				cnt <= {{(DCLT_CNT_W-1){1'b0}}, 1'b1};
				stop_cnt <= '0;
				rcs <= 1'b0;
			end else begin
				if (cnt != '1)
					cnt <= cnt + 1'b1;
				if (stop_cnt != STOP_LIM)
					stop_cnt <= stop_cnt + 1'b1;
				else if (en && closed)
					rcs <= 1'b1;
			end
		end
	end

	// Tuning: coarse search, then fine tracking with saturation
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			coarse <= DCLT_COARSE_RST;
			fine <= DCLT_FINE_RST;
			diff <= '0;
			chill <= 1'b0;
			hits <= '0;
			lockc <= 1'b0;
			lockf <= 1'b0;
			oob <= 1'b0;
		end else begin
			if (lose) begin
				lockc <= 1'b0;
				lockf <= 1'b0;
				hits <= '0;
			end
			if (wr_val && !tracking) begin
				coarse <= bus.wdata[15:10];
				fine <= bus.wdata[9:0];
			end
			if (tracking && ref_rise && !rcs)
				chill <= chill_on && !chill;
			if (measure) begin
				diff <= err[DCLT_MULT_W:0];
				if (state == DCLT_COARSE) begin
					if (mag <= DCLT_TOL_COARSE)
						lockc <= 1'b1;
					else if (fast && coarse != '0)
						coarse <= coarse - 1'b1;
					else if (!fast && coarse != '1)
						coarse <= coarse + 1'b1;
				end else if (!stable) begin
					// Drift tracked every measurement
					if (fast && !fine_lo && mag != '0)
						fine <= fine - 1'b1;
					else if (!fast && !fine_hi && mag != '0)
						fine <= fine + 1'b1;
					if (mag <= tol) begin
						if (hits != DCLT_LOCK_HITS)
							hits <= hits + 1'b1;
						else
							lockf <= 1'b1;
					end else if (!lockf) begin
						hits <= '0;
					end
				end
				// Out of bounds set by each measurement that pushes past a limit
				oob <= fine_clip;
			end
		end
	end

	// Sticky flags: set wins over clear-on-read
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			flags <= '0;
			{rcs_prev, oob_prev, lockc_prev, lockf_prev, rdy_prev} <= '0;
		end else begin
			flags <= (rd_flags ? '0 : flags) | rise_ev;
			{rcs_prev, oob_prev, lockc_prev, lockf_prev, rdy_prev} <=
				{rcs, oob, lockc, lockf, ready};
		end
	end

	// Read mux
	wire [DCLT_ST_W-1:0] status = {rcs, lockc, lockf, oob, ready};
	wire [15:0] rd_mux =
		bus.addr == DCLT_ADDR_CTRL ? {8'h00, ctrl} :
		bus.addr == DCLT_ADDR_MULT ? mult :
		bus.addr == DCLT_ADDR_VAL ? {coarse, fine} :
		bus.addr == DCLT_ADDR_STATUS ? {11'h000, status} :
		bus.addr == DCLT_ADDR_IRQ_FLAGS ? {11'h000, flags} :
		bus.addr == DCLT_ADDR_IRQ_MASK ? {11'h000, mask} : 16'h0000;

	// Registered outputs
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			RDATA_O <= 16'h0000;
			IRQ_O <= 1'b0;
			COARSE_O <= DCLT_COARSE_RST;
			FINE_O <= DCLT_FINE_RST;
		end else begin
			RDATA_O <= bus.rd ? rd_mux : 16'h0000;
			IRQ_O <= |(((rd_flags ? '0 : flags) | rise_ev) & mask);
			COARSE_O <= coarse;
			FINE_O <= fine;
		end
	end
endmodule
`default_nettype wire

//--- include/dclt_pkg.sv
/*
 Constants, types and register map of the closed-loop tuner of the
 frequency-locked loop. Assumes a single clock CLK_I at 25 MHz and a
 reference clock that arrives as a plain asynchronous input.
*/
// Operation
// - Unstable mode keeps tracking drift, locks kept
// - Fine overflow or underflow sets out-of-bounds
// - Slow or stopped reference sets stopped flag
// - Stop detection takes a long count
// - Stopped reference holds tuning, resumes automatically
// - Stopped flag rise raises enabled interrupt
// - Chill cycles on by default, skip measurement
// - Quick lock on by default, relaxed criteria
// - Wake without lose-lock keeps configuration, locks
// - Lose-lock at disable clears locks, relocks
// - Retained locks resume fine tracking after wake
// - Closed-loop select starts regulation to target
// - Coarse and fine lock flags on completion
// - Ratio difference stored each measurement
// - Control writes ignored while not ready
package dclt_pkg;
	// Register offsets
	localparam logic [3:0] DCLT_ADDR_CTRL = 4'h0;
	localparam logic [3:0] DCLT_ADDR_MULT = 4'h1;
	localparam logic [3:0] DCLT_ADDR_VAL = 4'h2;
	localparam logic [3:0] DCLT_ADDR_STATUS = 4'h3;
	localparam logic [3:0] DCLT_ADDR_IRQ_FLAGS = 4'h4;
	localparam logic [3:0] DCLT_ADDR_IRQ_MASK = 4'h5;
	// Control bit positions
	localparam int DCLT_CTRL_ENABLE = 0;
	localparam int DCLT_CTRL_CLOSED = 1;
	localparam int DCLT_CTRL_STABLE = 2;
	localparam int DCLT_CTRL_CCDIS = 3;
	localparam int DCLT_CTRL_QLDIS = 4;
	localparam int DCLT_CTRL_LLAW = 5;
	// Status and interrupt bit positions
	localparam int DCLT_ST_READY = 0;
	localparam int DCLT_ST_OOB = 1;
	localparam int DCLT_ST_LOCKF = 2;
	localparam int DCLT_ST_LOCKC = 3;
	localparam int DCLT_ST_RCS = 4;
	localparam int DCLT_ST_W = 5;
	// Field widths and values
	localparam int DCLT_COARSE_W = 6;
	localparam int DCLT_FINE_W = 10;
	localparam int DCLT_MULT_W = 16;
	localparam int DCLT_CNT_W = 18;
	localparam logic [DCLT_FINE_W-1:0] DCLT_FINE_MAX = 10'h3FF;
	localparam logic [DCLT_FINE_W-1:0] DCLT_FINE_MIN = 10'h000;
	localparam logic [DCLT_FINE_W-1:0] DCLT_FINE_RST = 10'h200;
	localparam logic [DCLT_COARSE_W-1:0] DCLT_COARSE_RST = 6'h1F;
	localparam logic [DCLT_MULT_W-1:0] DCLT_MULT_RST = 16'h05B9;
	localparam logic [7:0] DCLT_CTRL_RST = 8'h00;
	// Largest multiplication factor, and stop timeout 2*max in cycles
	localparam int DCLT_MAX_MULT = 65535;
	localparam int DCLT_STOP_CYCLES = 2 * DCLT_MAX_MULT;
	// Lock: error within tolerance, fine strict and quick, and coarse
	localparam logic [DCLT_CNT_W-1:0] DCLT_TOL_STRICT = 18'h00001;
	localparam logic [DCLT_CNT_W-1:0] DCLT_TOL_QUICK = 18'h00004;
	localparam logic [DCLT_CNT_W-1:0] DCLT_TOL_COARSE = 18'h00040;
	localparam logic [2:0] DCLT_LOCK_HITS = 3'h3;
	// Tuner states, one-hot
	typedef enum logic [3:0] {
		DCLT_OFF = 4'h1,
		DCLT_OPEN = 4'h2,
		DCLT_COARSE = 4'h4,
		DCLT_FINE = 4'h8
	} dclt_state_t;
	// Bus request bundle
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} dclt_bus_t;
endpackage

//--- hdl/dclt_sync.sv
/*
 Two-flop synchroniser with rising edge detect on the second stage.
 Assumes an input asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dclt_sync (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic meta; // First stage, read only by second
	logic sync; // Second stage
	logic prev; // Delayed copy for edge detect
	// Synchronise and detect rising edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= async_i;
			sync <= meta;
			prev <= sync;
		end
	end
	assign level_o = sync;
	assign rise_o = sync & ~prev;
endmodule
`default_nettype wire

//--- dv/dclt_monitor.sv
/* Port checker of the tuner, bound to every tuner instance.
 Assumes the one-cycle register bus of the tuner. */
`timescale 1ns/1ps
`default_nettype none
module dclt_monitor (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic REF_CLK_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic IRQ_O,
	input wire logic [dclt_pkg::DCLT_COARSE_W-1:0] COARSE_O,
	input wire logic [dclt_pkg::DCLT_FINE_W-1:0] FINE_O
);
	import dclt_pkg::*;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	logic ref_d; // Last reference level
	logic [3:0] quiet; // Cycles since reference rise or write
	logic mask_on; // Some interrupt source enabled
	wire ref_rise = REF_CLK_I && !ref_d; // Reference rising
	wire mask_wr = WR_I && ADDR_I == DCLT_ADDR_IRQ_MASK; // Mask write
	// Helper state for the hold and mask checks
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ref_d <= 1'b0;
			quiet <= 4'h0;
			mask_on <= 1'b0;
		end else begin
			ref_d <= REF_CLK_I;
			mask_on <= mask_wr ? |WDATA_I[4:0] : mask_on;
			if (ref_rise || WR_I)
				quiet <= 4'h0;
			else if (quiet != 4'hF)
				quiet <= quiet + 4'h1;
		end
	end
	// No write in the last three cycles
	sequence s_no_wr;
		!$past(WR_I) && !$past(WR_I, 2) && !$past(WR_I, 3);
	endsequence
	a_rd_idle:
	assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
		else $error("read data outside slot");
	a_unmapped_zero:
	assert property (RD_I && ADDR_I > 4'h5 |=> RDATA_O == 16'h0000)
		else $error("unmapped read not zero");
	a_fine_step:
	assert property (s_no_wr |-> FINE_O - $past(FINE_O) + 10'h001 <= 10'h002)
		else $error("fine jumped");
	a_fine_no_wrap:
	assert property (s_no_wr ##0 $past(FINE_O) == 10'h3FF |-> FINE_O != 10'h000)
		else $error("fine wrapped up");
	a_fine_no_under:
	assert property (s_no_wr ##0 $past(FINE_O) == 10'h000 |-> FINE_O != 10'h3FF)
		else $error("fine wrapped down");
	a_coarse_step:
	assert property (s_no_wr |-> COARSE_O - $past(COARSE_O) + 6'h01 <= 6'h02)
		else $error("coarse jumped");
	a_ref_hold:
	assert property (quiet >= 4'h8 |-> $stable(FINE_O) && $stable(COARSE_O))
		else $error("tuning moved without reference");
	a_irq_masked:
	assert property (IRQ_O |-> mask_on || $past(mask_on))
		else $error("interrupt while masked");
endmodule
bind dclt_tuner dclt_monitor u_mon (.CLK_I(CLK_I), .NRST_I(NRST_I),
	.REF_CLK_I(REF_CLK_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
	.COARSE_O(COARSE_O), .FINE_O(FINE_O));
`default_nettype wire

//--- dv/dclt_ref_model.sv
/* Reference clock source: fixed period while run is high.
 Assumes the bench starts and stops it; idle level is low. */
`timescale 1ns/1ps
`default_nettype none
module dclt_ref_model #(
	parameter realtime HALF = 160.0
) (
	input wire logic run_i,
	output logic ref_o
);
	wire run_q; // Run with an offset off the bus clock edges
	assign #7 run_q = run_i;
	initial ref_o = 1'b0;
	// Steady slow square wave, stands low when stopped
	always begin
		wait (run_q === 1'b1);
		#HALF ref_o = 1'b1;
		#HALF ref_o = 1'b0;
	end
endmodule
`default_nettype wire

//--- dv/dclt_tuner_tb_top.sv
/* Bench of the tuner: register tasks, reference model, scenarios.
 Assumes the tuner reset values and the one-cycle register bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
	num_errors++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end
module dclt_tuner_tb_top;
	import dclt_pkg::*;
	logic clk, rst_n, ref_run, ref_clk, we, re, irq; // Bench nets
	logic [3:0] addr; // Register index
	logic [15:0] wdata, rdata; // Bus data
	logic [DCLT_COARSE_W-1:0] coarse; // Coarse value
	logic [DCLT_FINE_W-1:0] fine; // Fine value
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	dclt_ref_model REF (.run_i(ref_run), .ref_o(ref_clk));
	dclt_tuner DUT (.CLK_I(clk), .NRST_I(rst_n), .REF_CLK_I(ref_clk),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(we), .RD_I(re),
		.RDATA_O(rdata), .IRQ_O(irq), .COARSE_O(coarse), .FINE_O(fine));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cycle ceiling against a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 200000) begin
			num_errors++;
			final_report;
		end
	end
	task final_report;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	// Read data stands in the cycle after the strobe
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	// Poll one status bit until it reaches v
	task wt(input int b, input logic v, input int n);
		logic [15:0] d;
		rd(DCLT_ADDR_STATUS, d);
		for (int i = 0; i < n && d[b] !== v; i++)
			rd(DCLT_ADDR_STATUS, d);
		`CHK("status bit", v, d[b])
	endtask
	// Wait until the fine value reaches v
	task wf(input logic [9:0] v, input int n);
		for (int i = 0; i < n && fine !== v; i++)
			@(posedge clk) #1;
		`CHK("fine", v, fine)
	endtask
	task t_reset;
		logic [15:0] d;
		rd(DCLT_ADDR_CTRL, d);
		`CHK("ctrl", DCLT_CTRL_RST, d[7:0])
		rd(DCLT_ADDR_MULT, d);
		`CHK("mult", DCLT_MULT_RST, d)
		rd(4'hF, d);
		`CHK("unmapped", 16'h0000, d)
	endtask
	task t_lock;
		logic [15:0] d;
		wr(DCLT_ADDR_MULT, 16'h0008);
		wr(DCLT_ADDR_CTRL, 16'h0003);
		wt(DCLT_ST_LOCKC, 1'b1, 200);
		wt(DCLT_ST_LOCKF, 1'b1, 200);
		`CHK("irq masked", 1'b0, irq)
		wr(DCLT_ADDR_IRQ_MASK, 16'h0004);
		@(posedge clk) #1 `CHK("irq lock", 1'b1, irq)
		rd(DCLT_ADDR_IRQ_FLAGS, d);
		`CHK("lock flag", 1'b1, d[DCLT_ST_LOCKF])
		rd(DCLT_ADDR_IRQ_FLAGS, d);
		`CHK("irq cleared", 1'b0, irq)
		wr(DCLT_ADDR_IRQ_MASK, 16'h0000);
	endtask
	task t_wake;
		logic [15:0] d;
		wr(DCLT_ADDR_CTRL, 16'h0002);
		wr(DCLT_ADDR_CTRL, 16'h0003);
		rd(DCLT_ADDR_STATUS, d);
		`CHK("locks kept", 2'h3, d[3:2])
		wr(DCLT_ADDR_CTRL, 16'h0023);
		wr(DCLT_ADDR_CTRL, 16'h0022);
		rd(DCLT_ADDR_STATUS, d);
		`CHK("locks lost", 2'h0, d[3:2])
		wr(DCLT_ADDR_CTRL, 16'h003B);
		wt(DCLT_ST_LOCKC, 1'b1, 200);
		wt(DCLT_ST_LOCKF, 1'b1, 200);
	endtask
	task t_oob;
		logic [15:0] d;
		wr(DCLT_ADDR_MULT, 16'h003C);
		wf(DCLT_FINE_MAX, 12000);
		repeat (40) @(posedge clk);
		#1 `CHK("fine top", DCLT_FINE_MAX, fine)
		rd(DCLT_ADDR_STATUS, d);
		`CHK("over", 1'b1, d[DCLT_ST_OOB])
		wr(DCLT_ADDR_MULT, 16'h0001);
		wf(DCLT_FINE_MIN, 12000);
		repeat (40) @(posedge clk);
		rd(DCLT_ADDR_STATUS, d);
		`CHK("under", 1'b1, d[DCLT_ST_OOB])
		wr(DCLT_ADDR_MULT, 16'h0008);
		wt(DCLT_ST_OOB, 1'b0, 100);
		// Stable bit freezes fine even with a large error
		wr(DCLT_ADDR_CTRL, 16'h003F);
		wr(DCLT_ADDR_MULT, 16'h003C);
		repeat (200) @(posedge clk);
		#1 `CHK("fine frozen", DCLT_FINE_MIN, fine)
		wr(DCLT_ADDR_MULT, 16'h0008);
		wr(DCLT_ADDR_CTRL, 16'h003B);
	endtask
	task t_stop;
		logic [15:0] d;
		logic [9:0] f;
		int n;
		wr(DCLT_ADDR_IRQ_MASK, 16'h0010);
		ref_run <= 1'b0;
		n = 0;
		while (irq !== 1'b1 && n < DCLT_STOP_CYCLES + 99) begin
			@(posedge clk) #1 n++;
			if (n == 40)
				f = fine;
		end
		`CHK("stop", 1'b1, n > DCLT_STOP_CYCLES - 9 && n < DCLT_STOP_CYCLES + 40)
		`CHK("hold", f, fine)
		rd(DCLT_ADDR_IRQ_FLAGS, d);
		`CHK("stop flag", 1'b1, d[DCLT_ST_RCS])
		@(posedge clk);
		ref_run <= 1'b1;
		wt(DCLT_ST_RCS, 1'b0, 50);
		`CHK("irq idle", 1'b0, irq)
	endtask
	initial begin
		{rst_n, we, re, addr, wdata} = '0;
		ref_run = 1'b1;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_lock;
		t_wake;
		t_oob;
		t_stop;
		final_report;
	end
endmodule
`default_nettype wire
